/* hw/sopc_consts.svh */
`ifndef SOPC_CONSTS_SVH
`define SOPC_CONSTS_SVH

// register word indices; byte address is four times the index
`define SOPC_IDX_CLKOUT 16'hff06
`define SOPC_IDX_FLOAT 16'hff30
`define SOPC_IDX_PDATA 16'hff31
`define SOPC_IDX_TIMOUT 16'hffc1
`define SOPC_ADDR_W 18

// field positions
`define SOPC_FQ_LSB 0
`define SOPC_FQ_MSB 1
`define SOPC_CLKEN_BIT 3
`define SOPC_TIMEN_BIT 2
`define SOPC_TIMER_CHANNEL_SEL_BIT 3
`define SOPC_BIT2 2
`define SOPC_BIT3 3

// reset values
`define SOPC_RST_FQ 2'h0
`define SOPC_RST_EN 1'h0
`define SOPC_RST_TIMER_CHANNEL_SEL 1'h0
`define SOPC_RST_PDATA 1'h1
`define SOPC_RST_FLOAT 1'h0

// divider taps: divide by 8 is counter bit 2, by 64 is bit 5
`define SOPC_DIV_W 8
`define SOPC_DIV8_BIT 3'h2
`define SOPC_DIV64_BIT 3'h5

`endif

/* hw/sopc_div.sv */
`timescale 1ns/1ps
`include "sopc_consts.svh"

module sopc_div (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // slow oscillator, synchronous to clk_sys
    input wire logic slow_osc_clock,
    // ripple-free division chain
    output logic [`SOPC_DIV_W-1:0] div_cnt
);
    logic slow_prev;
    wire slow_rise = slow_osc_clock & ~slow_prev;

    // counter bit k toggles every 2^k slow edges, i.e. divides by 2^(k+1)
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            slow_prev <= 1'b1; // a source already high at release is no false edge
            div_cnt <= '0;
        end else begin
            slow_prev <= slow_osc_clock;
            if (slow_rise) begin
                div_cnt <= div_cnt + 1'b1;
            end
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    property p_div_step;
        slow_rise |=> div_cnt == $past(div_cnt) + 1'b1;
    endproperty
    a_div_step: assert property (p_div_step) else $error("divider missed a slow edge"); // RQ4
endmodule : sopc_div

/* hw/sopc_pkg.sv */
package sopc_pkg;
    typedef enum logic [1:0] {
        SOPC_FQ_DIV_LO = 2'b00,
        SOPC_FQ_DIV_HI = 2'b01,
        SOPC_FQ_SLOW = 2'b10,
        SOPC_FQ_FAST = 2'b11
    } sopc_freq_t;
endpackage : sopc_pkg

/* hw/sopc_top.sv */
// How it works
// RQ1: clock out enabled, data one, driven: clock signal
// RQ2: clock out disabled: pin high; enable resets 0
// RQ3: code 11 fast clock, 10 slow undivided
// RQ4: 01 divides 8/16/32, 00 64/128/256
// RQ5: timer out enabled, data one, driven: timer signal
// RQ6: timer out disabled: pin high; enable resets 0
// RQ7: data zero holds pin low regardless
// RQ8: float bit one puts pin high impedance
// RQ9: software keeps data one, float zero
// RQ10: plain output on bit 3: clock enable 0
// RQ11: plain output on bit 2: timer enable 0
// RQ12: enable switching may glitch the pin
// RQ13: start fast oscillator before selecting it
// RQ14: channel select picks timer 1 or 0
// RQ15: control fields read back last written value
`timescale 1ns/1ps
`include "sopc_consts.svh"

module sopc_top #(
    // slow oscillator option: 0 = 32.768 kHz, 1 = 76.8 kHz, 2 = 153.6 kHz
    parameter int unsigned SLOW_OPT = 0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [`SOPC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // special signal sources, synchronous to clk_sys
    input wire logic slow_osc_clock,
    input wire logic fast_osc_clock,
    input wire logic timer0_out,
    input wire logic timer1_out,
    // port bit 2 and bit 3 pins
    output logic port_bit2_out,
    output logic port_bit2_oe,
    output logic port_bit3_out,
    output logic port_bit3_oe
);
    import sopc_pkg::*;

    sopc_freq_t clock_out_freq_sel;
    logic clock_out_enable;
    logic timer_out_enable;
    logic timer_channel_sel;
    logic port_bit2;
    logic port_bit3;
    logic port_bit2_float;
    logic port_bit3_float;
    logic [`SOPC_DIV_W-1:0] div_cnt;

    // byte addresses of the four words
    localparam logic [`SOPC_ADDR_W-1:0] A_CLKOUT = {`SOPC_IDX_CLKOUT, 2'b00};
    localparam logic [`SOPC_ADDR_W-1:0] A_FLOAT = {`SOPC_IDX_FLOAT, 2'b00};
    localparam logic [`SOPC_ADDR_W-1:0] A_PDATA = {`SOPC_IDX_PDATA, 2'b00};
    localparam logic [`SOPC_ADDR_W-1:0] A_TIMOUT = {`SOPC_IDX_TIMOUT, 2'b00};

    // bus decode; a request is taken on the edge where waitrequest is low
    wire req = avs_read | avs_write;
    wire take_wr = avs_write & ~avs_waitrequest & avs_byteenable[0];
    wire sel_clkout = avs_address == A_CLKOUT;
    wire sel_float = avs_address == A_FLOAT;
    wire sel_pdata = avs_address == A_PDATA;
    wire sel_timout = avs_address == A_TIMOUT;
    wire [3:0] wd = avs_writedata[3:0];

    // read mux; unused and unmapped bits read as zero
    wire [3:0] rd_clkout = {clock_out_enable, 1'b0, clock_out_freq_sel};
    wire [3:0] rd_float = {port_bit3_float, port_bit2_float, 2'b00};
    wire [3:0] rd_pdata = {port_bit3, port_bit2, 2'b00};
    wire [3:0] rd_timout = {timer_channel_sel, timer_out_enable, 2'b00};
    wire [3:0] next_rd = sel_clkout ? rd_clkout :
                         sel_float ? rd_float :
                         sel_pdata ? rd_pdata :
                         sel_timout ? rd_timout : 4'h0; // RQ15

    // one wait state: readdata is loaded while the request waits
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            if (avs_read & avs_waitrequest) begin
                avs_readdata <= {28'h0, next_rd};
            end
        end
    end

    // control fields
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            clock_out_freq_sel <= sopc_freq_t'(`SOPC_RST_FQ); // RQ4
            clock_out_enable <= `SOPC_RST_EN; // RQ2
            timer_out_enable <= `SOPC_RST_EN; // RQ6
            timer_channel_sel <= `SOPC_RST_TIMER_CHANNEL_SEL; // RQ14
        end else if (take_wr && sel_clkout) begin
            clock_out_freq_sel <= sopc_freq_t'(wd[`SOPC_FQ_MSB:`SOPC_FQ_LSB]); // RQ15
            clock_out_enable <= wd[`SOPC_CLKEN_BIT]; // RQ15
        end else if (take_wr && sel_timout) begin
            timer_out_enable <= wd[`SOPC_TIMEN_BIT]; // RQ15
            timer_channel_sel <= wd[`SOPC_TIMER_CHANNEL_SEL_BIT]; // RQ15
        end
    end

    // port data and float bits for the two shared pins
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            port_bit2 <= `SOPC_RST_PDATA;
            port_bit3 <= `SOPC_RST_PDATA;
            port_bit2_float <= `SOPC_RST_FLOAT;
            port_bit3_float <= `SOPC_RST_FLOAT;
        end else if (take_wr && sel_pdata) begin
            port_bit2 <= wd[`SOPC_BIT2];
            port_bit3 <= wd[`SOPC_BIT3];
        end else if (take_wr && sel_float) begin
            port_bit2_float <= wd[`SOPC_BIT2];
            port_bit3_float <= wd[`SOPC_BIT3];
        end
    end

    sopc_div u_sopc_div (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .slow_osc_clock(slow_osc_clock),
        .div_cnt(div_cnt)
    );

    // divider taps move with the slow oscillator option, so the divide ratio
    // for codes 01 and 00 doubles with each step of the option
    wire [2:0] tap_hi = 3'(`SOPC_DIV8_BIT + SLOW_OPT);
    wire [2:0] tap_lo = 3'(`SOPC_DIV64_BIT + SLOW_OPT);
    wire clock_out_signal = (clock_out_freq_sel == SOPC_FQ_FAST) ? fast_osc_clock :
                            (clock_out_freq_sel == SOPC_FQ_SLOW) ? slow_osc_clock :
                            (clock_out_freq_sel == SOPC_FQ_DIV_HI) ? div_cnt[tap_hi] :
                            div_cnt[tap_lo]; // RQ3 RQ4
    wire timer_out_signal = timer_channel_sel ? timer1_out : timer0_out; // RQ14

    // pin level: data gates the special signal, disabled enable gives high
    wire next_b3_out = port_bit3 & (clock_out_enable ? clock_out_signal : 1'b1); // RQ1 RQ2 RQ7
    wire next_b2_out = port_bit2 & (timer_out_enable ? timer_out_signal : 1'b1); // RQ5 RQ6 RQ7

    // registered pins; the enable is not resynchronised to the source, so
    // switching it mid-period can leave a short pulse on the pin
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            port_bit3_out <= 1'b1;
            port_bit3_oe <= 1'b1;
            port_bit2_out <= 1'b1;
            port_bit2_oe <= 1'b1;
        end else begin
            port_bit3_out <= next_b3_out;
            port_bit3_oe <= ~port_bit3_float; // RQ8
            port_bit2_out <= next_b2_out;
            port_bit2_oe <= ~port_bit2_float; // RQ8
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_b3_special;
        clock_out_enable && port_bit3 && !port_bit3_float;
    endsequence
    sequence s_b2_special;
        timer_out_enable && port_bit2 && !port_bit2_float;
    endsequence

    property p_clk_drive;
        s_b3_special |=> port_bit3_oe && port_bit3_out == $past(clock_out_signal);
    endproperty
    a_clk_drive: assert property (p_clk_drive) else $error("clock out not on pin 3"); // RQ1

    property p_clk_off_high;
        !clock_out_enable && port_bit3 && !port_bit3_float |=> port_bit3_oe && port_bit3_out;
    endproperty
    a_clk_off_high: assert property (p_clk_off_high) else $error("pin 3 not high"); // RQ2

    property p_fast_sel;
        clock_out_freq_sel == SOPC_FQ_FAST |-> clock_out_signal == fast_osc_clock;
    endproperty
    a_fast_sel: assert property (p_fast_sel) else $error("fast clock not selected"); // RQ3

    property p_slow_sel;
        clock_out_freq_sel == SOPC_FQ_SLOW |-> clock_out_signal == slow_osc_clock;
    endproperty
    a_slow_sel: assert property (p_slow_sel) else $error("slow clock not selected"); // RQ3

    property p_div_sel;
        clock_out_freq_sel == SOPC_FQ_DIV_LO
            |-> clock_out_signal == div_cnt[`SOPC_DIV64_BIT + SLOW_OPT];
    endproperty
    a_div_sel: assert property (p_div_sel) else $error("wrong divider tap"); // RQ4

    property p_tim_drive;
        s_b2_special |=> port_bit2_oe && port_bit2_out == $past(timer_out_signal);
    endproperty
    a_tim_drive: assert property (p_tim_drive) else $error("timer out not on pin 2"); // RQ5

    property p_tim_off_high;
        !timer_out_enable && port_bit2 && !port_bit2_float |=> port_bit2_oe && port_bit2_out;
    endproperty
    a_tim_off_high: assert property (p_tim_off_high) else $error("pin 2 not high"); // RQ6

    property p_data_low;
        (!port_bit3 && !port_bit3_float) ##0 (!port_bit3 [*2])
            |-> port_bit3_oe && !port_bit3_out;
    endproperty
    a_data_low: assert property (p_data_low) else $error("pin 3 not held low"); // RQ7

    property p_float;
        port_bit2_float && port_bit3_float |=> !port_bit2_oe && !port_bit3_oe;
    endproperty
    a_float: assert property (p_float) else $error("pins not floated"); // RQ8

    property p_timer_channel_sel;
        s_b2_special ##0 timer_channel_sel |=> port_bit2_out == $past(timer1_out);
    endproperty
    a_timer_channel_sel: assert property (p_timer_channel_sel) else $error("timer 1 not on pin 2"); // RQ14

    property p_timer_channel_sel_t0;
        s_b2_special ##0 !timer_channel_sel |=> port_bit2_out == $past(timer0_out);
    endproperty
    a_timer_channel_sel_t0: assert property (p_timer_channel_sel_t0) else $error("timer 0 not on pin 2"); // RQ14

    property p_readback;
        take_wr && sel_clkout |=> avs_waitrequest && clock_out_enable == $past(wd[3])
            && clock_out_freq_sel == $past(wd[1:0]);
    endproperty
    a_readback: assert property (p_readback) else $error("control field lost write"); // RQ15
endmodule : sopc_top

/* tb/sopc_pin_model.sv */
`timescale 1ns/1ps

// outside circuit on both pins; a floated pin has no pull, so it shows a moving level
module sopc_pin_model (
    // clock
    input wire logic clk_sys,
    // pins from the block, index 0 is bit 2
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    // resolved pin levels
    output logic [1:0] level
);
    logic idle = 1'b0;

    // toggle so a stale driven value never passes for a floated one
    always @(posedge clk_sys) begin
        idle <= ~idle;
    end

    assign level = (pin_oe & pin_out) | (~pin_oe & {2{idle}});
endmodule : sopc_pin_model

/* tb/special_output_pin_control_test.sv */
`timescale 1ns/1ps

module special_output_pin_control_test;
    // bench signals
    logic clk_sys, resetn, rd_en, wr_en, slow, fast, t0, t1, wait_req;
    logic [17:0] addr;
    logic [31:0] wdata, rdata, r;
    logic [1:0] p_out, p_oe, lvl;
    logic [3:0] ph = 4'h0;
    int fails = 0;
    int tests_run = 0;
    int lens[4] = '{2048, 512, 128, 64};
    int exps[4] = '{4, 8, 16, 16};

    sopc_top u_sopc_top (.clk_sys(clk_sys), .resetn(resetn), .avs_address(addr),
        .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(4'hf),
        .avs_readdata(rdata), .avs_waitrequest(wait_req), .slow_osc_clock(slow),
        .fast_osc_clock(fast), .timer0_out(t0), .timer1_out(t1), .port_bit2_out(p_out[0]),
        .port_bit2_oe(p_oe[0]), .port_bit3_out(p_out[1]), .port_bit3_oe(p_oe[1]));
    sopc_pin_model u_sopc_pin_model (.clk_sys(clk_sys), .pin_out(p_out), .pin_oe(p_oe),
        .level(lvl));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // sources: timer0 period 2, fast period 4, slow period 8, timer1 period 16 clocks
    always @(posedge clk_sys) begin
        ph <= ph + 4'h1;
    end
    assign {t1, slow, fast, t0} = ph;

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one avalon transfer; held until waitrequest is seen low at an edge
    task bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
        addr <= {idx, 2'b00};
        wr_en <= w;
        rd_en <= ~w;
        wdata <= d;
        do @(posedge clk_sys); while (wait_req !== 1'b0);
        r = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge clk_sys);
    endtask : bus

    // rising edges seen on one pin over a window of clocks
    task count(input int b, input int len, output int c);
        logic prev;
        prev = lvl[b];
        c = 0;
        repeat (len) begin
            @(posedge clk_sys);
            if (lvl[b] === 1'b1 && prev === 1'b0) c++;
            prev = lvl[b];
        end
    endtask : count

    task t_reset;
        chk("pins", 4'hf, {p_out, p_oe});
        bus(1'b0, 16'hff06, 0);
        chk("clock out reg", 0, r);
        bus(1'b0, 16'hffc1, 0);
        chk("timer out reg", 0, r);
        bus(1'b0, 16'hff31, 0);
        chk("port data reg", 32'hc, r);
        bus(1'b0, 16'hff30, 0);
        chk("float reg", 0, r);
    endtask : t_reset

    task t_readback;
        bus(1'b1, 16'hff06, 32'hb);
        bus(1'b0, 16'hff06, 0);
        chk("clock out reg", 32'hb, r);
        bus(1'b1, 16'hffc1, 32'hc);
        bus(1'b0, 16'hffc1, 0);
        chk("timer out reg", 32'hc, r);
        bus(1'b0, 16'hff07, 0);
        chk("unmapped", 0, r);
        bus(1'b1, 16'hff07, 32'hf);
        bus(1'b0, 16'hff06, 0);
        chk("unmapped write", 32'hb, r);
        bus(1'b1, 16'hffc1, 0);
    endtask : t_readback

    task t_freq;
        int c;
        // fast source runs from time zero, so it may be chosen at once
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 16'hff06, 32'h8 | k);
            repeat (4) @(posedge clk_sys);
            count(1, lens[k], c);
            chk("clock out rises", exps[k], c);
        end
        bus(1'b1, 16'hff06, 0);
        repeat (4) @(posedge clk_sys);
        count(1, 64, c);
        chk("bit3 idle rises", 0, c);
        chk("bit3 idle level", 1, lvl[1]);
    endtask : t_freq

    task t_timer;
        int c;
        bus(1'b1, 16'hffc1, 32'h4);
        repeat (4) @(posedge clk_sys);
        count(0, 64, c);
        chk("timer0 rises", 32, c);
        bus(1'b1, 16'hffc1, 32'hc);
        repeat (4) @(posedge clk_sys);
        count(0, 64, c);
        chk("timer1 rises", 4, c);
    endtask : t_timer

    task t_override;
        int c;
        bus(1'b1, 16'hff06, 32'h9);
        bus(1'b1, 16'hff31, 32'h0);
        repeat (4) @(posedge clk_sys);
        count(0, 64, c);
        chk("bit2 data low rises", 0, c);
        count(1, 64, c);
        chk("bit3 data low rises", 0, c);
        chk("data low pins", 4'h3, {lvl, p_oe});
        bus(1'b1, 16'hff31, 32'hc);
        bus(1'b1, 16'hff30, 32'hc);
        repeat (4) @(posedge clk_sys);
        chk("floated oe", 0, p_oe);
        bus(1'b1, 16'hff30, 0);
        bus(1'b1, 16'hffc1, 0);
        repeat (4) @(posedge clk_sys);
        count(0, 64, c);
        chk("bit2 idle rises", 0, c);
        chk("bit2 idle level", 1, lvl[0]);
    endtask : t_override

    task final_report;
        if (fails == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    // whole run is near 3200 clocks; this span is about six times that
    initial begin
        #200us;
        fails++;
        final_report;
    end

    initial begin
        resetn = 1'b0;
        rd_en = 1'b0;
        wr_en = 1'b0;
        addr = 18'h0;
        wdata = 32'h0;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_reset;
        t_readback;
        t_freq;
        t_timer;
        t_override;
        // second reset mid-run: every field written above must fall back
        resetn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_reset;
        final_report;
    end
endmodule : special_output_pin_control_test
